// ===== shared/lbfc_map.vh
// Summary of operation
// - interrupt request raised when break-field reception ends
// - break-receive trigger always reads back as zero
// - break-receive trigger self-clears after correct break reception
// - interrupt request raised when break-field transmission ends
// - break-send trigger always reads back as zero
// - break-send trigger self-clears when break transmission ends
// - rewriting a trigger during a break operation restarts that operation
`ifndef LBFC_MAP_VH
`define LBFC_MAP_VH
// break length sent, in bit times
`define LBFC_TX_BREAK_BITS 13
// least low length accepted as a break, in bit times
`define LBFC_RX_BREAK_BITS 11
// default operating clocks per bit time
`define LBFC_BIT_CLKS 16
// reset values
`define LBFC_RST_TXD 1'b1
`define LBFC_RST_IRQ 1'b0
`endif

// ===== hw/lbfc_bit_timer.v
`timescale 1ns/1ps
// free-running bit-time tick, restarted on demand
module lbfc_bit_timer #(
  parameter CLKS = 16
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // control
  input  wire        restart,
  output reg         tick_q
);
  reg [15:0] cnt_q;
  // count operating clocks, pulse once per bit time
  always @(posedge clock)
  begin
    if (!rst_n || restart)
    begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (cnt_q == CLKS[15:0] - 16'h0001)
    begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule // lbfc_bit_timer

// ===== hw/lbfc_top.v
`timescale 1ns/1ps
`include "lbfc_map.vh"
// break field send/receive control for a lin serial unit
module lbfc_top #(
  parameter BIT_CLKS = `LBFC_BIT_CLKS,
  parameter TX_BITS  = `LBFC_TX_BREAK_BITS,
  parameter RX_BITS  = `LBFC_RX_BREAK_BITS
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // mode bits
  input  wire        unit_power_on,
  input  wire        transmit_enable_bit,
  input  wire        receive_enable_bit,
  input  wire        bit_order_select,
  input  wire        tx_level_invert,
  // trigger writes, one-cycle strobes carrying a 1
  input  wire        break_receive_trigger,
  input  wire        break_send_trigger,
  // serial data from shifter and receive line
  input  wire        tx_data_bit,
  input  wire        rxd,
  // status
  output reg         break_receive_trigger_rd_q,
  output reg         break_send_trigger_rd_q,
  output reg         break_receive_flag_q,
  output reg         break_send_busy_q,
  output reg         rx_break_irq_q,
  output reg         tx_break_irq_q,
  output reg         rx_break_error_q,
  output reg         msb_first_q,
  output reg         txd_q
);
  // receive sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_LOW  = 2'h2;
  // break lengths and counter ceiling at counter width
  localparam [4:0] RX_LIMIT = RX_BITS[4:0];
  localparam [4:0] TX_LAST  = TX_BITS[4:0] - 5'h01;
  localparam [4:0] CNT_MAX  = 5'h1F;
  reg  [1:0] rx_st_q;
  reg  [1:0] rx_st_d;
  reg  [4:0] rx_cnt_q;
  reg  [4:0] tx_cnt_q;
  wire       rx_tick;
  wire       tx_tick;
  wire       rx_go;
  wire       tx_go;
  wire       rx_ok;
  wire       rx_bad;
  wire [1:0] tmr_restart;
  wire [1:0] tmr_tick;
  genvar     gi;

  // a side may run only with power and its own enable
  function side_on;
    input power;
    input enable;
    begin
      side_on = power && enable;
    end
  endfunction

  // start conditions; restart when rewritten mid-operation
  assign rx_go = break_receive_trigger &&
                 side_on(unit_power_on, receive_enable_bit);
  assign tx_go = break_send_trigger &&
                 side_on(unit_power_on, transmit_enable_bit);

  // receive timer restarts again on the first low sample
  assign tmr_restart[0] = rx_go || (rx_st_q == ST_WAIT && !rxd);
  assign tmr_restart[1] = tx_go;
  assign rx_tick        = tmr_tick[0];
  assign tx_tick        = tmr_tick[1];

  // one bit timer per side, 0 receive and 1 send
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_timer
      lbfc_bit_timer #(.CLKS(BIT_CLKS)) u_timer (
        .clock   (clock),
        .rst_n   (rst_n),
        .restart (tmr_restart[gi]),
        .tick_q  (tmr_tick[gi])
      );
    end
  endgenerate

  // a low run ends; long enough is a break
  assign rx_ok  = rx_st_q == ST_LOW && rxd && rx_cnt_q >= RX_LIMIT;
  assign rx_bad = rx_st_q == ST_LOW && rxd && rx_cnt_q < RX_LIMIT;

  // receive state selection
  always @*
  begin
    rx_st_d = rx_st_q;
    case (rx_st_q)
      ST_IDLE: rx_st_d = ST_IDLE;
      ST_WAIT: if (!rxd) rx_st_d = ST_LOW;
      ST_LOW:  if (rxd) rx_st_d = ST_IDLE;
      default: rx_st_d = ST_IDLE;
    endcase
    if (rx_go)
      rx_st_d = ST_WAIT;
    if (!side_on(unit_power_on, receive_enable_bit))
      rx_st_d = ST_IDLE;
  end

  // break reception sequencing
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_st_q              <= ST_IDLE;
      rx_cnt_q             <= 5'h00;
      break_receive_flag_q <= 1'b0;
      rx_break_irq_q       <= `LBFC_RST_IRQ;
      rx_break_error_q     <= 1'b0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      // whole bit times of the low run, saturating
      if (rx_st_q != ST_LOW || rx_go)
        rx_cnt_q <= 5'h00;
      else if (rx_tick && rx_cnt_q != CNT_MAX)
        rx_cnt_q <= rx_cnt_q + 5'h01;
      if (rx_go)
        break_receive_flag_q <= 1'b1;
      else if (rx_ok || rx_st_d == ST_IDLE)
        break_receive_flag_q <= 1'b0;
      rx_break_irq_q   <= rx_ok && !rx_go;
      rx_break_error_q <= rx_bad && !rx_go;
    end
  end

  // break transmission sequencing
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      break_send_busy_q <= 1'b0;
      tx_cnt_q          <= 5'h00;
      tx_break_irq_q    <= `LBFC_RST_IRQ;
    end
    else if (tx_go)
    begin
      break_send_busy_q <= 1'b1;
      tx_cnt_q          <= 5'h00;
      tx_break_irq_q    <= 1'b0;
    end
    else if (!side_on(unit_power_on, transmit_enable_bit))
    begin
      break_send_busy_q <= 1'b0;
      tx_cnt_q          <= 5'h00;
      tx_break_irq_q    <= 1'b0;
    end
    else if (break_send_busy_q && tx_tick &&
             tx_cnt_q == TX_LAST)
    begin
      break_send_busy_q <= 1'b0;
      tx_cnt_q          <= 5'h00;
      tx_break_irq_q    <= 1'b1;
    end
    else
    begin
      // count sent bit times
      if (break_send_busy_q && tx_tick)
        tx_cnt_q <= tx_cnt_q + 5'h01;
      tx_break_irq_q <= 1'b0;
    end
  end

  // trigger read-back, never shows a written 1
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      break_receive_trigger_rd_q <= 1'b0;
      break_send_trigger_rd_q    <= 1'b0;
    end
    else
    begin
      break_receive_trigger_rd_q <= 1'b0;
      break_send_trigger_rd_q    <= 1'b0;
    end
  end

  // bit order handed on to the shifter
  // order select
  always @(posedge clock)
  begin
    if (!rst_n)
      msb_first_q <= 1'b0;
    else
      msb_first_q <= bit_order_select;
  end

  // line output; polarity applied last so the break obeys it too
  // level invert
  always @(posedge clock)
  begin
    if (!rst_n)
      txd_q <= `LBFC_RST_TXD;
    else if (!unit_power_on)
      txd_q <= `LBFC_RST_TXD ^ tx_level_invert;
    else if (break_send_busy_q)
      txd_q <= 1'b0 ^ tx_level_invert;
    else
      txd_q <= tx_data_bit ^ tx_level_invert;
  end
endmodule // lbfc_top

// ===== testbench/lbfc_monitor.sv
`timescale 1ns/1ps
// port-level checks on break send and receive control
module lbfc_monitor #(
  parameter BIT_CLKS = 16,
  parameter TX_BITS  = 13
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // mode inputs and send trigger
  input  wire        unit_power_on,
  input  wire        transmit_enable_bit,
  input  wire        bit_order_select,
  input  wire        tx_level_invert,
  input  wire        break_send_trigger,
  // line inputs
  input  wire        tx_data_bit,
  input  wire        rxd,
  // status outputs
  input  wire        break_receive_trigger_rd_q,
  input  wire        break_send_trigger_rd_q,
  input  wire        break_receive_flag_q,
  input  wire        break_send_busy_q,
  input  wire        rx_break_irq_q,
  input  wire        tx_break_irq_q,
  input  wire        msb_first_q,
  input  wire        txd_q
);
  reg [7:0] n_q;
  // cycles since last taken send trigger, saturating
  always @(posedge clock)
    n_q <= (!rst_n || (break_send_trigger && unit_power_on &&
      transmit_enable_bit)) ? 8'h00 : n_q + {7'h0, ~&n_q};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rrd; !break_receive_trigger_rd_q; endproperty
  a_rrd: assert property (p_rrd) else $error("rx readback");
  property p_srd; !break_send_trigger_rd_q; endproperty
  a_srd: assert property (p_srd) else $error("tx readback");
  property p_rxe; rx_break_irq_q |-> $past(break_receive_flag_q) &&
    !break_receive_flag_q && $past(rxd); endproperty
  a_rxe: assert property (p_rxe) else $error("rx end");
  property p_txe; tx_break_irq_q |-> $past(break_send_busy_q) &&
    !break_send_busy_q; endproperty
  a_txe: assert property (p_txe) else $error("tx end");
  property p_len; tx_break_irq_q |-> n_q >= TX_BITS * BIT_CLKS - 2 &&
    n_q <= TX_BITS * BIT_CLKS + 3; endproperty
  a_len: assert property (p_len) else $error("tx length");
  property p_low; break_send_busy_q && $past(break_send_busy_q) &&
    !tx_level_invert |-> !txd_q; endproperty
  a_low: assert property (p_low) else $error("break level");
  property p_dat; !break_send_busy_q && !$past(break_send_busy_q) &&
    $past(unit_power_on) && $past(transmit_enable_bit) |->
    txd_q == ($past(tx_data_bit) ^ $past(tx_level_invert)); endproperty
  a_dat: assert property (p_dat) else $error("tx data");
  property p_ord; msb_first_q == $past(bit_order_select); endproperty
  a_ord: assert property (p_ord) else $error("bit order");
endmodule // lbfc_monitor

bind lbfc_top lbfc_monitor #(.BIT_CLKS(BIT_CLKS), .TX_BITS(TX_BITS))
  lbfc_monitor_inst (.clock, .rst_n, .unit_power_on, .transmit_enable_bit,
  .bit_order_select, .tx_level_invert, .break_send_trigger, .tx_data_bit,
  .rxd, .break_receive_trigger_rd_q, .break_send_trigger_rd_q,
  .break_receive_flag_q, .break_send_busy_q, .rx_break_irq_q,
  .tx_break_irq_q, .msb_first_q, .txd_q);

// ===== testbench/lbfc_lin_node.sv
`timescale 1ns/1ps
// far lin node driving a break onto the receive line
module lbfc_lin_node #(
  parameter BIT_CLKS = 4
) (
  // clock and break request
  input  wire       clock,
  input  wire       go,
  input  wire [4:0] len,
  // receive line, recessive high
  output reg        rxd = 1'b1
);
  integer n = 0;
  // low for len bit times, recessive high otherwise
  always @(posedge clock)
  begin
    n <= go ? len * BIT_CLKS : n - (n != 0);
    rxd <= (n == 0);
  end
endmodule // lbfc_lin_node

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // stimulus and observed outputs
  reg clock = 0, rst_n = 0, unit_power_on = 0, transmit_enable_bit = 0;
  reg receive_enable_bit = 0, bit_order_select = 0, tx_level_invert = 0;
  reg break_receive_trigger = 0, break_send_trigger = 0, tx_data_bit = 1;
  reg go = 0;
  reg [4:0] len = 0;
  wire rxd, break_receive_trigger_rd_q, break_send_trigger_rd_q;
  wire break_receive_flag_q, break_send_busy_q, rx_break_irq_q;
  wire tx_break_irq_q, rx_break_error_q, msb_first_q, txd_q;
  integer failures = 0, check_count = 0;
  lbfc_top #(.BIT_CLKS(4)) lbfc_top_inst (.clock, .rst_n, .unit_power_on,
    .transmit_enable_bit, .receive_enable_bit, .bit_order_select,
    .tx_level_invert, .break_receive_trigger, .break_send_trigger,
    .tx_data_bit, .rxd, .break_receive_trigger_rd_q, .break_send_trigger_rd_q,
    .break_receive_flag_q, .break_send_busy_q, .rx_break_irq_q,
    .tx_break_irq_q, .rx_break_error_q, .msb_first_q, .txd_q);
  lbfc_lin_node #(.BIT_CLKS(4)) lbfc_lin_node_inst (.clock, .go, .len, .rxd);
  // 200 mhz clock
  initial forever #2.5 clock = ~clock;
  task chk(input logic s, input logic e, input string nm);
  begin
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // one-cycle trigger strobe
  task pul(input logic rx);
  begin
    @(negedge clock);
    break_receive_trigger = rx;
    break_send_trigger = !rx;
    @(negedge clock);
    // strobe ends; a trigger is never written back to 0
    break_receive_trigger = 0;
    break_send_trigger = 0;
  end
  endtask
  // bounded wait: 0 tx irq, 1 rx irq, 2 rx error
  task wt(input integer k);
    integer n;
  begin
    n = 0;
    while (n < 400 && (k == 0 ? tx_break_irq_q : k == 1 ? rx_break_irq_q
      : rx_break_error_q) !== 1'b1)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 400)
    begin
      $display("ERROR wait %0d expected 1 seen 0", k);
      failures++;
      stop_test;
    end
  end
  endtask
  // far node break of l bit times
  task brk(input [4:0] l);
  begin
    @(negedge clock);
    len = l;
    go = 1;
    @(negedge clock);
    go = 0;
  end
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(negedge clock);
    rst_n = 1;
    unit_power_on = 1;
    @(negedge clock);
    transmit_enable_bit = 1;
    receive_enable_bit = 1;
    pul(0);
    @(negedge clock);
    chk(break_send_busy_q, 1, "busy");
    chk(break_send_trigger_rd_q, 0, "send rd");
    repeat (20) @(negedge clock);
    pul(0);
    wt(0);
    chk(break_send_busy_q, 0, "busy");
    repeat (2) @(negedge clock);
    chk(txd_q, 1, "txd idle");
    transmit_enable_bit = 0;
    pul(0);
    @(negedge clock);
    chk(break_send_busy_q, 0, "refused");
    pul(1);
    @(negedge clock);
    chk(break_receive_flag_q, 1, "flag");
    chk(break_receive_trigger_rd_q, 0, "recv rd");
    brk(12);
    wt(1);
    chk(break_receive_flag_q, 0, "flag");
    pul(1);
    brk(5);
    wt(2);
    chk(rx_break_irq_q, 0, "short irq");
    pul(1);
    @(negedge clock);
    chk(break_receive_flag_q, 1, "rearm");
    receive_enable_bit = 0;
    // options change only once both sides are off
    @(negedge clock);
    bit_order_select = 1;
    tx_level_invert = 1;
    tx_data_bit = 0;
    @(negedge clock);
    transmit_enable_bit = 1;
    repeat (3) @(negedge clock);
    chk(msb_first_q, 1, "msb");
    chk(txd_q, 1, "invert");
    stop_test;
  end
endmodule // testbench
